// ### dv/lcs_host_model.sv
// Purpose: host side of the register strobe port
// Assumes: requests launched at the falling clock edge
// Notes:   idle address is inverted after each transfer, idle data after writes, so stale values never match
`timescale 1ns/10ps
`default_nettype none
module lcs_host_model (
  input  wire logic       i_clk,    // device clock
  output logic            o_wr_en,  // write strobe
  output logic            o_rd_en,  // read strobe
  output logic [7:0]      o_addr,   // register offset
  output logic [7:0]      o_wdata,  // write data
  input  wire logic [7:0] i_rdata,  // read data
  input  wire logic       i_rvalid  // read valid pulse
);
  // idle until the bench asks for a transfer
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'hff;
    o_wdata = 8'h00;
  end

  // one-cycle write strobe, then scrambled idle values
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : write

  // write, then read the same offset on the very next edge
  task automatic write_read(input logic [7:0] a, input logic [7:0] wd,
                            output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = wd;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~wd;
    d = i_rdata;
    v = i_rvalid;
  endtask : write_read

  // answer stands one cycle, so it is taken at the next falling edge
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr  = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d = i_rdata;
    v = i_rvalid;
  endtask : read
endmodule : lcs_host_model
`default_nettype wire

// ### dv/tb_led_current_source_regs.sv
// Purpose: self-checking bench for the led current source registers
// Assumes: inputs change at the falling clock edge
// Notes:   status path is checked for its exact two-cycle latency
`timescale 1ns/10ps
`default_nettype none
module tb_led_current_source_regs;
  import lcs_pkg::*;
  logic            clk, nrst, wr_en, rd_en, rvalid, auto_en, pump;
  logic [7:0]      addr, wdata, rdata;
  logic [3:0]      pwm_on, pattern_on, headroom_low, drive, enabled, flag;
  logic [3:0][7:0] level;
  int              failures, check_count;

  lcs_host_model host_u (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
  lcs_regs dut_u (.i_clk(clk), .i_nrst(nrst), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_pwm_on(pwm_on), .i_pattern_on(pattern_on), .i_headroom_low(headroom_low),
    .i_pump_automatic_enable(auto_en), .o_source_drive(drive),
    .o_source_enabled(enabled), .o_level_code(level), .o_headroom_flag(flag),
    .o_pump_run(pump));

  // 50 ns clock
  always #25 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // read one register and judge both valid and data
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host_u.read(a, d, v);
    check("rvalid", {31'h0, v}, 32'h1);
    check($sformatf("reg %h", a), {24'h0, d}, {24'h0, exp});
  endtask : rd_chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic t_reset_values();
    check("enabled", enabled, 4'h1);
    check("drive", drive, 4'h1);
    check("level", level, 32'h0000_0040);
    rd_chk(LCS_ADDR_MODE, 8'h03);
    rd_chk(8'h02, 8'h40);
    for (int i = 3; i < 6; i++) rd_chk(8'(i), 8'h00);
    rd_chk(LCS_ADDR_STATUS, 8'h00);
  endtask : t_reset_values

  // full-scale and boundary codes, plus the gaps around the level block
  task automatic t_levels();
    logic [7:0] v[4] = '{8'hff, 8'h01, 8'h80, 8'h7f};
    logic [7:0] rb;
    logic       rv;
    for (int i = 0; i < 4; i++) host_u.write(8'(i + 2), v[i]);
    for (int i = 0; i < 4; i++) rd_chk(8'(i + 2), v[i]);
    check("level", level, 32'h7f80_01ff);
    host_u.write_read(8'h02, 8'h55, rb, rv);
    check("rvalid", {31'h0, rv}, 32'h1);
    check("level1 readback", {24'h0, rb}, 32'h0000_0055);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h00, 8'h00);
  endtask : t_levels

  task automatic t_status_pump();
    check("pump idle", {31'h0, pump}, 32'h0);
    headroom_low = 4'b1010;
    @(negedge clk);
    check("flag early", flag, 4'h0);
    @(negedge clk);
    check("flag", flag, 4'ha);
    @(negedge clk);
    check("pump on", {31'h0, pump}, 32'h1);
    auto_en = 1'b0;
    @(negedge clk);
    check("pump auto off", {31'h0, pump}, 32'h0);
    auto_en = 1'b1;
    @(negedge clk);
    check("pump restart", {31'h0, pump}, 32'h1);
    host_u.write(LCS_ADDR_STATUS, 8'hff);
    rd_chk(LCS_ADDR_STATUS, 8'h0a);
    host_u.write(LCS_ADDR_MODE, 8'h00);
    repeat (2) @(negedge clk);
    check("pump off", {31'h0, pump}, 32'h0);
    headroom_low = 4'b0000;
  endtask : t_status_pump

  // three mode words, each using every mode code once, each hardware source toggled both ways
  task automatic t_modes();
    logic [7:0] m[3]  = '{8'he4, 8'h1b, 8'h36};
    logic [3:0] p[6]  = '{4'b1011, 4'b0100, 4'b0000, 4'b0010, 4'b0001, 4'b0000};
    logic [3:0] g[6]  = '{4'b0111, 4'b1000, 4'b0000, 4'b0001, 4'b0000, 4'b0100};
    logic [3:0] e[6]  = '{4'b0010, 4'b1110, 4'b0100, 4'b0111, 4'b0011, 4'b0110};
    logic [3:0] en[3] = '{4'b1110, 4'b0111, 4'b0111};
    for (int k = 0; k < 3; k++) begin
      host_u.write(LCS_ADDR_MODE, m[k]);
      rd_chk(LCS_ADDR_MODE, m[k]);
      check("enabled", enabled, en[k]);
      for (int j = 0; j < 2; j++) begin
        pwm_on     = p[2 * k + j];
        pattern_on = g[2 * k + j];
        repeat (2) @(negedge clk);
        check("drive", drive, e[2 * k + j]);
      end
    end
  endtask : t_modes

  // watchdog, far beyond the roughly 75 cycles the run needs
  initial begin
    #100us;
    failures++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    auto_en = 1'b1;
    pwm_on = 4'h0;
    pattern_on = 4'h1;
    headroom_low = 4'h0;
    failures = 0;
    check_count = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_reset_values();
    t_levels();
    t_status_pump();
    t_modes();
    stop_test();
  end
endmodule : tb_led_current_source_regs
`default_nettype wire

// ### hw/lcs_flag_if.sv
// Purpose: carries raw and synchronised headroom flags between modules
// Assumes: single clock domain on the receiving side
// Notes:   raw side is driven by the top, flag side by the synchroniser
`timescale 1ns/10ps
`default_nettype none
interface lcs_flag_if #(
  parameter int unsigned WIDTH = 4
);
  logic [WIDTH-1:0] raw;   // unsynchronised low indications
  logic [WIDTH-1:0] flag;  // synchronised status bits

  modport src (output raw, input flag);
  modport syn (input raw, output flag);
endinterface : lcs_flag_if
`default_nettype wire

// ### hw/lcs_flag_sync.sv
// Purpose: two-stage synchroniser for the per-source headroom flags
// Assumes: flags are slow levels from the analog comparators
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module lcs_flag_sync
  import lcs_pkg::*;
#(
  parameter int unsigned WIDTH = LCS_NUM_SRC
) (
  input  wire logic i_clk,     // device clock
  input  wire logic i_nrst,    // async reset, active low
  lcs_flag_if.syn   flags      // raw in, synchronised out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } lcs_sync_t;

  lcs_sync_t s_q;
  lcs_sync_t s_d;

  // shift raw flags through both stages
  always_comb begin
    s_d        = s_q;
    s_d.stage1 = flags.raw;     // [RULE10]
    s_d.stage2 = s_q.stage1;
  end

  // status bits clear at reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;                // [RULE8]
    end else begin
      s_q <= s_d;
    end
  end

  assign flags.flag = s_q.stage2;  // [RULE7]

endmodule : lcs_flag_sync
`default_nettype wire

// ### hw/lcs_pkg.sv
// Purpose: constants for the led current source register bank
// Assumes: 8-bit register port driven by the serial control decoder
// Notes:   offsets are the register addresses seen by that decoder
// Operation
// RULE1 - each source obeys 2-bit mode: off, on, pwm, pattern generator
// RULE2 - mode register 0x01 holds four 2-bit fields, source four highest
// RULE3 - after reset source one mode is 3, others are 0
// RULE4 - 8-bit level code sets current linearly at 0.1 mA per count
// RULE5 - level codes for sources one to four sit at 0x02 to 0x05
// RULE6 - after reset source one level is 0x40, others zero
// RULE7 - status bit is 1 while the source headroom is below 200 mV
// RULE8 - read-only status at 0x2b, source four bit 3 down to bit 0
// RULE9 - automatic pump starts when a source is enabled and one is low
// RULE10 - status writes ignored; status follows synchronised low indications
package lcs_pkg;

  localparam int unsigned LCS_NUM_SRC   = 4;
  localparam int unsigned LCS_ADDR_W    = 8;
  localparam int unsigned LCS_DATA_W    = 8;
  localparam int unsigned LCS_MODE_W    = 2;
  localparam int unsigned LCS_SYNC_DEPTH = 2;

  // register offsets
  localparam logic [7:0] LCS_ADDR_MODE   = 8'h01;
  localparam logic [7:0] LCS_ADDR_LEVEL1 = 8'h02;
  localparam logic [7:0] LCS_ADDR_LEVEL4 = 8'h05;
  localparam logic [7:0] LCS_ADDR_STATUS = 8'h2b;

  // values after reset
  localparam logic [7:0] LCS_MODE_RST   = 8'h03;
  localparam logic [7:0] LCS_LEVEL1_RST = 8'h40;
  localparam logic [7:0] LCS_LEVEL_RST  = 8'h00;
  localparam logic [7:0] LCS_ZERO       = 8'h00;

  // operating mode codes
  localparam logic [1:0] LCS_MODE_OFF = 2'h0;
  localparam logic [1:0] LCS_MODE_ON  = 2'h1;
  localparam logic [1:0] LCS_MODE_PWM = 2'h2;
  localparam logic [1:0] LCS_MODE_PAT = 2'h3;

  // analog scaling carried for the current cells, not used by logic
  localparam int unsigned LCS_STEP_UA      = 100;
  localparam int unsigned LCS_HEADROOM_MV  = 200;

endpackage : lcs_pkg

// ### hw/lcs_regs.sv
// Purpose: register bank for four led current sources
// Assumes: serial decoder gives one-cycle read and write strobes
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module lcs_regs
  import lcs_pkg::*;
(
  input  wire logic                  i_clk,            // device clock, 20 MHz
  input  wire logic                  i_nrst,           // async reset, active low
  input  wire logic                  i_wr_en,          // write strobe
  input  wire logic                  i_rd_en,          // read strobe
  input  wire logic [LCS_ADDR_W-1:0] i_addr,           // register offset
  input  wire logic [LCS_DATA_W-1:0] i_wdata,          // write data
  output logic      [LCS_DATA_W-1:0] o_rdata,          // read data
  output logic                       o_rvalid,         // read data valid pulse
  input  wire logic [3:0]            i_pwm_on,         // pwm on/off per source
  input  wire logic [3:0]            i_pattern_on,     // pattern on/off per source
  input  wire logic [3:0]            i_headroom_low,   // below 200 mV per source
  input  wire logic                  i_pump_automatic_enable, // auto pump mode
  output logic      [3:0]            o_source_drive,   // source conducting
  output logic      [3:0]            o_source_enabled, // mode not off
  output logic      [3:0][7:0]       o_level_code,     // level code per source
  output logic      [3:0]            o_headroom_flag,  // synchronised status
  output logic                       o_pump_run        // charge pump request
);

  typedef struct packed {
    logic [7:0]      mode;
    logic [3:0][7:0] level;
    logic [3:0]      drive;
    logic            pump;
    logic [7:0]      rdata;
    logic            rvalid;
  } lcs_state_t;

  lcs_state_t s_q;
  lcs_state_t s_d;

  lcs_flag_if #(.WIDTH(LCS_NUM_SRC)) flag_bus ();

  // pick the on/off control for one source from its mode
  function automatic logic lcs_mode_drive(input logic [1:0] mode,
                                          input logic       pwm,
                                          input logic       pat);
    logic on;
    on = 1'b0;
    case (mode)
      LCS_MODE_OFF: on = 1'b0;
      LCS_MODE_ON:  on = 1'b1;
      LCS_MODE_PWM: on = pwm;
      LCS_MODE_PAT: on = pat;
      default:      on = 1'b0;
    endcase
    return on;
  endfunction : lcs_mode_drive

  // true when an offset lies inside the level block 0x02..0x05
  function automatic logic lcs_is_level(input logic [7:0] addr);
    return (addr >= LCS_ADDR_LEVEL1) && (addr <= LCS_ADDR_LEVEL4);
  endfunction : lcs_is_level

  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [3:0] enabled;

  // raw comparator levels go through the synchroniser
  assign flag_bus.raw = i_headroom_low;

  lcs_flag_sync #(
    .WIDTH (LCS_NUM_SRC)
  ) u_flag_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .flags  (flag_bus.syn)
  );

  // offset minus base selects the level slot
  assign wr_idx = 2'(i_addr - LCS_ADDR_LEVEL1);  // [RULE5]
  assign rd_idx = wr_idx;

  // a source counts as enabled whenever its mode is not off
  always_comb begin
    for (int i = 0; i < LCS_NUM_SRC; i++) begin
      enabled[i] = (s_q.mode[2*i +: 2] != LCS_MODE_OFF);
    end
  end

  // next state: register writes, drive decode, pump and read port
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = i_rd_en;
    // write decode; status offset is read-only so it has no case here
    if (i_wr_en) begin
      if (i_addr == LCS_ADDR_MODE) begin
        s_d.mode = i_wdata;                    // [RULE2]
      end else if (lcs_is_level(i_addr)) begin
        s_d.level[wr_idx] = i_wdata;           // [RULE5] [RULE4]
      end
    end
    // writes to the status offset fall through untouched [RULE10]
    for (int i = 0; i < LCS_NUM_SRC; i++) begin
      s_d.drive[i] = lcs_mode_drive(s_q.mode[2*i +: 2],
                                    i_pwm_on[i], i_pattern_on[i]);  // [RULE1]
    end
    // pump holds while auto is on and any source stays enabled, drops when auto is off or all are off
    if (!i_pump_automatic_enable || (enabled == 4'h0)) begin
      s_d.pump = 1'b0;
    end else if (|flag_bus.flag) begin
      s_d.pump = 1'b1;                         // [RULE9]
    end
    // read mux, unmapped offsets read as zero
    s_d.rdata = LCS_ZERO;
    if (i_rd_en) begin
      if (i_addr == LCS_ADDR_MODE) begin
        s_d.rdata = s_q.mode;
      end else if (lcs_is_level(i_addr)) begin
        s_d.rdata = s_q.level[rd_idx];
      end else if (i_addr == LCS_ADDR_STATUS) begin
        s_d.rdata = {4'h0, flag_bus.flag};     // [RULE8]
      end
    end
  end

  // reset values: source one in pattern mode at level 0x40
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q          <= '0;
      s_q.mode     <= LCS_MODE_RST;            // [RULE3]
      s_q.level[0] <= LCS_LEVEL1_RST;          // [RULE6]
      s_q.level[1] <= LCS_LEVEL_RST;
      s_q.level[2] <= LCS_LEVEL_RST;
      s_q.level[3] <= LCS_LEVEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops, except source enabled decoded from the mode; level code scales current in the cells
  assign o_rdata         = s_q.rdata;
  assign o_rvalid        = s_q.rvalid;
  assign o_source_drive  = s_q.drive;
  assign o_source_enabled = enabled;
  assign o_level_code    = s_q.level;          // [RULE4]
  assign o_headroom_flag = flag_bus.flag;      // [RULE7]
  assign o_pump_run      = s_q.pump;

  // checks on the register bank
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  logic past_valid_q;
  logic [1:0] past_cnt_q;

  // reset-to-run counter so the status assertions skip the first cycles
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      past_cnt_q   <= 2'h0;
      past_valid_q <= 1'b0;
    end else begin
      if (past_cnt_q != 2'h3) begin
        past_cnt_q <= past_cnt_q + 2'h1;
      end
      past_valid_q <= (past_cnt_q == 2'h3);
    end
  end

  a_mode_write: assert property ( // [RULE2]
    (i_wr_en && i_addr == LCS_ADDR_MODE) |=> (s_q.mode == $past(i_wdata))
  ) else $error("mode register did not take written value");

  a_level_write: assert property ( // [RULE5]
    (i_wr_en && i_addr == LCS_ADDR_LEVEL4) |=> (o_level_code[3] == $past(i_wdata))
  ) else $error("source four level did not take written value");

  a_level_readback: assert property ( // [RULE4]
    (i_wr_en && i_addr == LCS_ADDR_LEVEL1) ##1 (i_rd_en && i_addr == LCS_ADDR_LEVEL1
      && !i_wr_en) |=> (o_rvalid && o_rdata == $past(i_wdata, 2))
  ) else $error("source one level read back wrong");

  a_mode_decode: assert property ( // [RULE1]
    (s_q.mode[1:0] == LCS_MODE_PWM) |=> (o_source_drive[0] == $past(i_pwm_on[0]))
  ) else $error("pwm mode did not follow pwm input");

  a_off_silent: assert property ( // [RULE1]
    (s_q.mode[7:6] == LCS_MODE_OFF) [*2] |-> !o_source_drive[3]
  ) else $error("source four drives in off mode");

  a_status_latency: assert property ( // [RULE10]
    past_valid_q |-> (o_headroom_flag == $past(i_headroom_low, 2))
  ) else $error("status not two cycles behind raw flags");

  a_status_read: assert property ( // [RULE8]
    (i_rd_en && i_addr == LCS_ADDR_STATUS) |=>
      (o_rdata == {4'h0, $past(o_headroom_flag)})
  ) else $error("status read returned wrong bits");

  a_status_level: assert property ( // [RULE7]
    past_valid_q && $past(i_headroom_low[1], 2) |-> o_headroom_flag[1]
  ) else $error("low headroom not reported for source two");

  a_pump_start: assert property ( // [RULE9]
    (i_pump_automatic_enable && (|enabled) && (|o_headroom_flag)) |=> o_pump_run
  ) else $error("pump did not start on low headroom");

  a_pump_stop: assert property ( // [RULE9]
    (!i_pump_automatic_enable || enabled == 4'h0) |=> !o_pump_run
  ) else $error("pump ran while disabled or all sources off");

  a_unmapped_zero: assert property ( // [RULE10]
    (i_rd_en && i_addr == 8'h06) |=> (o_rvalid && o_rdata == LCS_ZERO)
  ) else $error("unmapped read not zero");

  a_reset_values: assert property ( // [RULE3]
    $rose(i_nrst) |-> (s_q.mode == LCS_MODE_RST && o_level_code[0] == LCS_LEVEL1_RST
      && o_level_code[1] == LCS_LEVEL_RST)
  ) else $error("reset values wrong");

  a_reset_outputs: assert property ( // [RULE6]
    $rose(i_nrst) |-> (!o_rvalid && !o_pump_run && o_headroom_flag == 4'h0
      && o_level_code[2] == LCS_LEVEL_RST && o_level_code[3] == LCS_LEVEL_RST)
  ) else $error("outputs not at reset values");

  // read port: valid and data stand one cycle only, zero otherwise
  a_rvalid_pulse: assert property ( // [RULE5]
    i_rd_en |=> o_rvalid
  ) else $error("read strobe gave no valid pulse");

  a_rvalid_idle: assert property ( // [RULE5]
    !i_rd_en |=> (!o_rvalid && o_rdata == LCS_ZERO)
  ) else $error("read data stood without a read");

  a_mode_read: assert property ( // [RULE2]
    (i_rd_en && i_addr == LCS_ADDR_MODE) |=> (o_rvalid && o_rdata == $past(s_q.mode))
  ) else $error("mode read returned wrong value");

  a_level_four_read: assert property ( // [RULE5]
    (i_rd_en && i_addr == LCS_ADDR_LEVEL4) |=> (o_rdata == $past(o_level_code[3]))
  ) else $error("source four level read returned wrong value");

  // registers move only on a write to their own offset
  a_level_one: assert property ( // [RULE5]
    (i_wr_en && i_addr == LCS_ADDR_LEVEL1) |=> (o_level_code[0] == $past(i_wdata))
  ) else $error("source one level did not take written value");

  a_level_hold: assert property ( // [RULE5]
    !i_wr_en |=> $stable(o_level_code)
  ) else $error("level codes changed without a write");

  a_mode_hold: assert property ( // [RULE2]
    !i_wr_en |=> $stable(s_q.mode)
  ) else $error("mode register changed without a write");

  a_status_ignored: assert property ( // [RULE10]
    (i_wr_en && i_addr == LCS_ADDR_STATUS) |=> ($stable(s_q.mode) && $stable(o_level_code))
  ) else $error("status write disturbed a register");

  // per-mode drive decode, one source per code so each field is seen
  a_off_one: assert property ( // [RULE1]
    (s_q.mode[1:0] == LCS_MODE_OFF) |=> !o_source_drive[0]
  ) else $error("source one drives in off mode");

  a_on_drive: assert property ( // [RULE1]
    (s_q.mode[3:2] == LCS_MODE_ON) |=> o_source_drive[1]
  ) else $error("source two not driving in on mode");

  a_pwm_three: assert property ( // [RULE1]
    (s_q.mode[5:4] == LCS_MODE_PWM) |=> (o_source_drive[2] == $past(i_pwm_on[2]))
  ) else $error("source three did not follow pwm input");

  a_pat_decode: assert property ( // [RULE1]
    (s_q.mode[7:6] == LCS_MODE_PAT) |=> (o_source_drive[3] == $past(i_pattern_on[3]))
  ) else $error("pattern mode did not follow pattern input");

  // status bits read back in the low nibble, high nibble always zero
  a_status_nibble: assert property ( // [RULE8]
    (i_rd_en && i_addr == LCS_ADDR_STATUS) |=> (o_rvalid && o_rdata[7:4] == 4'h0)
  ) else $error("status read set unused bits");

  a_status_set: assert property ( // [RULE7]
    past_valid_q && $past(i_headroom_low[3], 2) |-> o_headroom_flag[3]
  ) else $error("low headroom not reported for source four");

  a_status_clear: assert property ( // [RULE7]
    past_valid_q && !$past(i_headroom_low[3], 2) |-> !o_headroom_flag[3]
  ) else $error("source four flagged with adequate headroom");

  // pump keeps running until auto is dropped or every source is off
  a_pump_hold: assert property ( // [RULE9]
    (o_pump_run && i_pump_automatic_enable && (|enabled)) |=> o_pump_run
  ) else $error("pump dropped while still wanted");

  a_pump_quiet: assert property ( // [RULE9]
    (!o_pump_run && !(|o_headroom_flag)) |=> !o_pump_run
  ) else $error("pump started with no low headroom");

  c_mode_write: cover property (i_wr_en && i_addr == LCS_ADDR_MODE);
  c_status_read: cover property (
    (i_rd_en && i_addr == LCS_ADDR_STATUS) ##1 (o_rdata != LCS_ZERO));
  c_pump_cycle: cover property ($rose(o_pump_run) ##[1:20] $fell(o_pump_run));
  c_status_write: cover property (i_wr_en && i_addr == LCS_ADDR_STATUS);
  c_readback: cover property ((i_wr_en && i_addr == LCS_ADDR_LEVEL1) ##1 i_rd_en);

endmodule : lcs_regs
`default_nettype wire
